// file: watchdog_clock_monitor.sv
// Windowed watchdog and clock monitor sharing one open-drain fault pin
// What this block does
// [R1] Watchdog works only with option bit 2 at 0; fault pin then has pull-up.
// [R2] Detectors off in reset; afterwards armed with widest window and monitor on.
// [R3] Only the first keyed service write configures window and monitor until reset.
// [R4] Later writes must match key, window and monitor bits or raise an error.
// [R5] Service before upper limit and not within 2048 idle clocks of last one.
// [R6] Boot ROM entry suppresses lower check and services; exit services and re-arms.
// [R7] Fault pin held low 16 more cycles after it reads low, then released.
// [R8] Service window restarts when the fault pin returns high.
// [R9] Service writes are ignored while the fault pin is driven.
// [R10] A pin stuck low at power-up ends by a watchdog timeout and release.
// [R11] Monitor holds pin low while clock is slow, releases 16 cycles after recovery.
// [R12] Slow-clock threshold lies between 10 Hz and 5 kHz instruction clock.
// [R13] Watchdog counting pauses in stop and doze modes.
// [R14] Monitor stays active in stop and doze, so stop raises a monitor error.
// [R15] Doze exit gives a hardware service; stop exit reloads the window.
// [R16] Service register reads show zeros in the key field.
// [R17] First service after reset may come early without a lower-window error.
// [R18] Idle pending flag sets on selected idle counter bit toggle; software clears.
// [R19] Window bits pick 8k, 16k, 32k or 64k upper limit; lower fixed 2048.
// [R20] All window timing counts idle-timer clocks.
// [R21] A first write with a bad key errors and keeps reset settings.
module watchdog_clock_monitor
    import wdcm_pkg::*;
#(
    parameter int CM_LIMIT = CM_CYCLES
) (
    // Clock, resets, enable
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic por_n,
    input wire logic clk_en,
    // Register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Core status
    input wire logic [7:0] option_byte,
    input wire logic instr_tick,
    input wire logic stop_mode,
    input wire logic doze_mode,
    input wire logic boot_rom_enter,
    input wire logic boot_rom_exit,
    // Fault pin, open drain
    input wire logic fault_pin_i,
    output logic fault_pin_o,
    output logic fault_pin_oe,
    output logic fault_pullup_en,
    output logic idle_counter_pending
);
    function automatic logic [16:0] upper_limit(input logic [1:0] win_code);
        upper_limit = 17'(UPPER_BASE) << win_code; // [R19]
    endfunction : upper_limit

    svc_fields_s wfield;
    logic wd_on;
    logic idle_tick;
    logic [16:0] idle_counter;
    logic idle_toggle;
    logic [2:0] idle_sel;
    logic [16:0] low_mask;
    logic [1:0] win;
    logic cm_en;
    logic configured;
    logic lower_en;
    logic [16:0] svc_count;
    logic [19:0] gap_count;
    logic cm_fail;
    logic wd_err_seen;
    logic cm_err_seen;
    logic stop_q;
    logic doze_q;
    pulse_e pstate;
    logic [4:0] hold_cnt;
    logic svc_wr;
    logic svc_take;
    logic key_ok;
    logic all_ok;
    logic early;
    logic svc_timeout;
    logic wd_trig;
    logic restart;
    logic pin_back;

    assign wfield = svc_fields_s'(wdata);
    assign wd_on = ~option_byte[OPT_WD_BIT]; // [R1]
    assign idle_tick = clk_en & instr_tick; // [R20]
    assign svc_wr = clk_en & wr & (addr == ADDR_SVC);
    assign svc_take = svc_wr & wd_on & ~fault_pin_oe; // [R9]
    assign key_ok = wfield.key == SVC_KEY;
    assign all_ok = key_ok & (wfield.win == win) & (wfield.cm == cm_en); // [R4]
    // First write is exempt from the early check
    assign early = configured & lower_en & (svc_count < 17'(LOWER_LIMIT)); // [R5] [R17]
    assign svc_timeout = svc_count >= upper_limit(win); // [R5]
    assign wd_trig = svc_take & (configured ? (~all_ok | early) : ~key_ok) // [R21]
        | (svc_timeout & (pstate == PULSE_IDLE)); // [R10]
    assign pin_back = (pstate == PULSE_RELEASE) & fault_pin_i;
    assign restart = svc_take & ~wd_trig | pin_back // [R8]
        | (doze_q & ~doze_mode) | (stop_q & ~stop_mode) // [R15]
        | boot_rom_enter | boot_rom_exit; // [R6]
    // Selected bit flips only when every bit below it carries
    assign low_mask = (17'h1 << (IDLE_SEL_BASE + int'(idle_sel))) - 17'h1;
    assign idle_toggle = idle_tick & (&(idle_counter | ~low_mask)); // [R18]

    // Idle timer survives external reset; only power-on clears it
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            idle_counter <= '0;
        end else if (idle_tick) begin
            idle_counter <= idle_counter + 17'd1; // [R18]
        end
    end

    // Pending flag and timer select; a toggle beats a clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            idle_counter_pending <= 1'b0;
            idle_sel <= TSEL_RESET;
        end else if (clk_en) begin
            if (idle_toggle) begin
                idle_counter_pending <= 1'b1; // [R18]
            end else if (wr && addr == ADDR_STAT && wdata[ST_PEND]) begin
                idle_counter_pending <= 1'b0;
            end
            if (wr && addr == ADDR_TSEL) begin
                idle_sel <= (wdata[2:0] > 3'h4) ? 3'h4 : wdata[2:0];
            end
        end
    end

    // Configuration from the first keyed write only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            win <= WIN_RESET; // [R2]
            cm_en <= CM_RESET; // [R2]
            configured <= 1'b0;
        end else if (clk_en && svc_take && !configured && key_ok) begin
            win <= wfield.win; // [R3]
            cm_en <= wfield.cm; // [R3]
            configured <= 1'b1; // [R3]
        end
    end

    // Mode edge history
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stop_q <= 1'b0;
            doze_q <= 1'b0;
        end else if (clk_en) begin
            stop_q <= stop_mode;
            doze_q <= doze_mode;
        end
    end

    // Lower window check is lifted while running from boot ROM
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lower_en <= 1'b1;
        end else if (clk_en) begin
            if (boot_rom_enter) begin
                lower_en <= 1'b0; // [R6]
            end else if (boot_rom_exit) begin
                lower_en <= 1'b1; // [R6]
            end
        end
    end

    // Service window counter in idle-timer clocks
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            svc_count <= '0;
        end else if (clk_en) begin
            if (restart) begin
                svc_count <= '0; // [R4] [R8] [R15]
            end else if (idle_tick && !stop_mode && !doze_mode && wd_on
                         && pstate == PULSE_IDLE && !svc_timeout) begin
                svc_count <= svc_count + 17'd1; // [R13] [R20]
            end
        end
    end

    // Gap between instruction ticks; counting on the system clock keeps it alive in stop
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_count <= '0;
            cm_fail <= 1'b0;
        end else if (clk_en) begin
            if (instr_tick) begin
                gap_count <= '0;
            end else if (gap_count < 20'(CM_LIMIT)) begin
                gap_count <= gap_count + 20'd1;
            end
            cm_fail <= cm_en && wd_on && !instr_tick && gap_count >= 20'(CM_LIMIT); // [R12] [R14]
        end
    end

    // Sticky error flags, set beats clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wd_err_seen <= 1'b0;
            cm_err_seen <= 1'b0;
        end else if (clk_en) begin
            if (wd_trig) begin
                wd_err_seen <= 1'b1;
            end else if (wr && addr == ADDR_STAT && wdata[ST_WDERR]) begin
                wd_err_seen <= 1'b0;
            end
            if (cm_fail) begin
                cm_err_seen <= 1'b1;
            end else if (wr && addr == ADDR_STAT && wdata[ST_CMERR]) begin
                cm_err_seen <= 1'b0;
            end
        end
    end

    // Fault pulse sequencer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pstate <= PULSE_IDLE;
            hold_cnt <= '0;
            fault_pin_oe <= 1'b0;
        end else if (clk_en) begin
            unique case (pstate)
                PULSE_IDLE: begin
                    if (wd_on && (wd_trig || cm_fail)) begin
                        pstate <= PULSE_PULL;
                        fault_pin_oe <= 1'b1; // [R7] [R11] [R14]
                    end
                end
                PULSE_PULL: begin
                    // Tail starts only once the wire is really low
                    if (!fault_pin_i) begin
                        pstate <= PULSE_HOLD; // [R7]
                        hold_cnt <= '0;
                    end
                end
                PULSE_HOLD: begin
                    if (cm_fail) begin
                        hold_cnt <= '0; // [R11]
                    end else if (hold_cnt == 5'(HOLD_CYCLES - 1)) begin
                        pstate <= PULSE_RELEASE;
                        fault_pin_oe <= 1'b0; // [R7] [R11]
                    end else begin
                        hold_cnt <= hold_cnt + 5'd1;
                    end
                end
                PULSE_RELEASE: begin
                    if (fault_pin_i) begin
                        pstate <= PULSE_IDLE; // [R8]
                    end
                end
            endcase
            if (!wd_on) begin
                pstate <= PULSE_IDLE; // [R1]
                fault_pin_oe <= 1'b0;
            end
        end
    end

    // Pin drive level and pull-up
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fault_pin_o <= 1'b0;
            fault_pullup_en <= 1'b0;
        end else if (clk_en) begin
            fault_pin_o <= 1'b0;
            fault_pullup_en <= wd_on; // [R1]
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (clk_en) begin
            rdata <= '0;
            if (rd) begin
                unique case (addr)
                    ADDR_SVC: rdata <= {win, 5'h00, cm_en}; // [R16]
                    ADDR_STAT: rdata <= {2'h0, cm_fail, fault_pin_oe, configured,
                                         cm_err_seen, wd_err_seen, idle_counter_pending};
                    ADDR_TSEL: rdata <= {5'h00, idle_sel};
                    default: rdata <= '0;
                endcase
            end
        end
    end

    opt_disable_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
        option_byte[OPT_WD_BIT] && $past(option_byte[OPT_WD_BIT]) |-> !fault_pin_oe)
        else $error("fault pin driven with watchdog disabled");

    reset_defaults_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R2]
        !configured |-> win == WIN_RESET && cm_en == CM_RESET)
        else $error("reset settings lost before configuration");

    key_read_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R16]
        clk_en && rd && addr == ADDR_SVC |=> rdata[5:1] == 5'h00)
        else $error("key field visible on read");

    timeout_pull_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
        clk_en && wd_on && svc_timeout && pstate == PULSE_IDLE |=> fault_pin_oe)
        else $error("timeout did not pull the fault pin");

    hold_release_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R7]
        clk_en && pstate == PULSE_HOLD && !cm_fail && hold_cnt == 5'(HOLD_CYCLES - 1)
        |=> !fault_pin_oe && pstate == PULSE_RELEASE)
        else $error("fault pin not released after hold");

    ignore_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R9]
        fault_pin_oe && svc_wr |=> $stable(configured) && $stable(win) && $stable(cm_en))
        else $error("service write taken while pin driven");

    stop_pause_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R13]
        stop_mode && stop_q && !boot_rom_enter && !boot_rom_exit && !svc_wr && !pin_back
        |=> svc_count == $past(svc_count))
        else $error("watchdog counted during stop");

    pend_set_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R18]
        idle_toggle |=> idle_counter_pending)
        else $error("pending flag missed a toggle");

    bad_first_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R21]
        svc_take && !configured && !key_ok |=> wd_err_seen && !configured)
        else $error("bad first key not flagged");

    pullup_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
        clk_en |=> fault_pullup_en != $past(option_byte[OPT_WD_BIT]))
        else $error("pull-up does not follow the option bit");

    cfg_lock_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
        configured |=> $stable(win) && $stable(cm_en))
        else $error("settings changed after configuration");

    mismatch_err_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R4]
        svc_take && configured && !all_ok |=> wd_err_seen)
        else $error("mismatched service not flagged");

    early_err_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
        svc_take && configured && lower_en && svc_count < 17'(LOWER_LIMIT) |=> wd_err_seen)
        else $error("early service not flagged");

    boot_enter_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R6]
        clk_en && boot_rom_enter |=> !lower_en && svc_count == '0)
        else $error("boot entry did not service");

    pull_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R7]
        clk_en && wd_on && pstate == PULSE_PULL && fault_pin_i
        |=> fault_pin_oe && pstate == PULSE_PULL)
        else $error("pin released before it read low");

    back_restart_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8]
        clk_en && pin_back |=> svc_count == '0)
        else $error("window not restarted on pin return");

    cm_pull_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11]
        clk_en && wd_on && cm_fail && pstate == PULSE_IDLE |=> fault_pin_oe)
        else $error("monitor error did not pull the pin");

    cm_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11]
        clk_en && wd_on && cm_fail && pstate == PULSE_HOLD |=> fault_pin_oe && hold_cnt == '0)
        else $error("pin tail ran while clock slow");

    doze_pause_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R13]
        clk_en && doze_mode && !restart |=> $stable(svc_count))
        else $error("watchdog counted during doze");

    stop_exit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R15]
        clk_en && stop_q && !stop_mode |=> svc_count == '0)
        else $error("window not reloaded after stop");

    first_ok_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R17]
        svc_take && !configured && key_ok && !svc_timeout |=> configured && svc_count == '0)
        else $error("first keyed service not taken");

    pend_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R18]
        clk_en && wr && addr == ADDR_STAT && wdata[ST_PEND] && !idle_toggle
        |=> !idle_counter_pending)
        else $error("pending flag not cleared");
endmodule : watchdog_clock_monitor

// file: wdcm_pkg.sv
// Constants, layouts and types shared by the watchdog and clock monitor
package wdcm_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] ADDR_SVC = 2'h0;
    localparam logic [1:0] ADDR_STAT = 2'h1;
    localparam logic [1:0] ADDR_TSEL = 2'h2;
    // Service register field positions
    localparam int SVC_WIN_LSB = 6;
    localparam int SVC_KEY_LSB = 1;
    localparam int SVC_CM_BIT = 0;
    localparam logic [4:0] SVC_KEY = 5'h0c;
    // Reset values of the service settings
    localparam logic [1:0] WIN_RESET = 2'h3;
    localparam logic CM_RESET = 1'b1;
    localparam logic [2:0] TSEL_RESET = 3'h0;
    // Option byte bit that enables the watchdog when zero
    localparam int OPT_WD_BIT = 2;
    // Status register bit positions
    localparam int ST_PEND = 0;
    localparam int ST_WDERR = 1;
    localparam int ST_CMERR = 2;
    localparam int ST_CONF = 3;
    localparam int ST_DRIVE = 4;
    localparam int ST_CMFAIL = 5;
    // Window limits in idle-timer clocks
    localparam int LOWER_LIMIT = 2048;
    localparam int UPPER_BASE = 8192;
    localparam int IDLE_SEL_BASE = 12;
    // Fault pulse tail after the pin reads low, in system clocks
    localparam int HOLD_CYCLES = 16;
    // Clock monitor rejects instruction clocks slower than 1 kHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int CM_THRESHOLD_NS = 1000000;
    localparam int CM_CYCLES = CM_THRESHOLD_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [1:0] win;
        logic [4:0] key;
        logic cm;
    } svc_fields_s;

    typedef enum logic [1:0] {PULSE_IDLE, PULSE_PULL, PULSE_HOLD, PULSE_RELEASE} pulse_e;
endpackage : wdcm_pkg

// file: fault_line_model.sv
// Fault wire with pull-up and the reset circuit input that watches it
module fault_line_model (
    // Clock and speed choice
    input wire logic sys_clk,
    input wire logic slow,
    // Open-drain driver of the device
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic pullup_en,
    // Level seen on the wire
    output logic level
);
    logic [1:0] lag = 2'h0;
    logic last = 1'b1;

    // Heavy load on the wire lets a slow edge take three cycles to fall
    always @(posedge sys_clk) begin
        lag <= pin_oe ? ((lag == 2'h3) ? lag : lag + 2'h1) : 2'h0;
        last <= level;
    end

    // Without pull-up a released wire floats, so never show a stable level
    always_comb begin
        if (pin_oe && (!slow || lag == 2'h3)) begin
            level = pin_o;
        end else if (pullup_en) begin
            level = 1'b1;
        end else begin
            level = ~last;
        end
    end
endmodule : fault_line_model

// file: watchdog_clock_monitor_tb.sv
// Self-checking bench for the watchdog and clock monitor
module watchdog_clock_monitor_tb;
    import wdcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0;
    logic resetn = 1'b0, por_n = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
    logic stop_mode = 1'b0, doze_mode = 1'b0, boot_rom_enter = 1'b0, boot_rom_exit = 1'b0;
    logic instr_tick = 1'b0, tick_on = 1'b1, slow = 1'b0, level;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, option_byte = 8'h00, rdata, q;
    logic fault_pin_o, fault_pin_oe, fault_pullup_en, idle_counter_pending;
    int fails = 0, checked = 0, cycles = 0, n = 0;

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) instr_tick <= tick_on;

    watchdog_clock_monitor #(.CM_LIMIT(50)) uut (
        .sys_clk(sys_clk), .resetn(resetn), .por_n(por_n), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .option_byte(option_byte), .instr_tick(instr_tick), .stop_mode(stop_mode),
        .doze_mode(doze_mode), .boot_rom_enter(boot_rom_enter), .boot_rom_exit(boot_rom_exit),
        .fault_pin_i(level), .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
        .fault_pullup_en(fault_pullup_en), .idle_counter_pending(idle_counter_pending)
    );

    fault_line_model line (
        .sys_clk(sys_clk), .slow(slow), .pin_o(fault_pin_o), .pin_oe(fault_pin_oe),
        .pullup_en(fault_pullup_en), .level(level)
    );

    task automatic give_verdict;
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // Hang guard, well above the longest expected run
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            $display("BAD %0t run did not finish", $time);
            give_verdict;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic wait_oe(input logic v, input int max);
        n = 0;
        while (fault_pin_oe !== v && n < max) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask : wait_oe

    // Pre counts edges of the pulse already gone before the call
    task automatic pulse_end(input int pre);
        wait_oe(1'b0, 80);
        chk(n + pre >= 16 && n + pre <= 40 && !fault_pin_oe, 1'b1, "pulse length");
        wr_reg(ADDR_STAT, 8'h07);
    endtask : pulse_end

    task automatic service(input logic [7:0] d, input logic e);
        wr_reg(ADDR_SVC, d);
        if (e) begin
            wait_oe(1'b1, 5);
            chk(fault_pin_oe, 1'b1, "error pulse");
            pulse_end(n);
        end else begin
            repeat (3) @(posedge sys_clk);
            #1 chk(fault_pin_oe, 1'b0, "unexpected error");
        end
    endtask : service

    task automatic do_reset;
        @(posedge sys_clk);
        resetn <= 1'b0;
        @(posedge sys_clk);
        #1 chk({fault_pullup_en, fault_pin_oe}, 2'b00, "pin in reset");
        @(posedge sys_clk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk(fault_pullup_en, 1'b1, "pull-up on");
    endtask : do_reset

    task automatic boot_pulse(input logic ex);
        @(posedge sys_clk);
        boot_rom_enter <= !ex;
        boot_rom_exit <= ex;
        @(posedge sys_clk);
        boot_rom_enter <= 1'b0;
        boot_rom_exit <= 1'b0;
    endtask : boot_pulse

    initial begin
        do_reset;
        rd_reg(ADDR_SVC, q);
        chk(q, 8'hc1, "svc after reset");
        rd_reg(ADDR_TSEL, q);
        chk(q, 8'h00, "idle select reset");
        wr_reg(ADDR_TSEL, 8'h07);
        rd_reg(ADDR_TSEL, q);
        chk(q, 8'h04, "idle select clamp");
        rd_reg(2'h3, q);
        chk(q, 8'h00, "unmapped read");
        slow <= 1'b1;
        service(8'h01, 1'b1);
        rd_reg(ADDR_SVC, q);
        chk(q, 8'hc1, "defaults kept");
        slow <= 1'b0;
        do_reset;
        service(8'h19, 1'b0);
        rd_reg(ADDR_SVC, q);
        chk(q, 8'h01, "svc readback");
        repeat (2100) @(posedge sys_clk);
        service(8'h19, 1'b0);
        repeat (2100) @(posedge sys_clk);
        service(8'hd9, 1'b1);
        service(8'h19, 1'b1);
        repeat (2100) @(posedge sys_clk);
        service(8'h18, 1'b1);
        // Bad write during a running pulse must leave no trace
        repeat (2100) @(posedge sys_clk);
        wr_reg(ADDR_SVC, 8'h00);
        wait_oe(1'b1, 5);
        wr_reg(ADDR_STAT, 8'h07);
        wr_reg(ADDR_SVC, 8'h00);
        rd_reg(ADDR_STAT, q);
        chk({q[ST_DRIVE], q[ST_WDERR]}, 2'b10, "ignored write");
        pulse_end(n + 6);
        wait_oe(1'b1, 8300);
        chk(n >= 8180 && n <= 8220, 1'b1, "upper limit");
        chk(idle_counter_pending, 1'b1, "idle pending set");
        wr_reg(ADDR_STAT, 8'h01);
        @(posedge sys_clk);
        #1 chk(idle_counter_pending, 1'b0, "idle pending clear");
        pulse_end(3);
        repeat (3000) @(posedge sys_clk);
        doze_mode <= 1'b1;
        repeat (9000) @(posedge sys_clk);
        #1 chk(fault_pin_oe, 1'b0, "paused in doze");
        @(posedge sys_clk);
        doze_mode <= 1'b0;
        service(8'h19, 1'b1);
        // Stopped clock while in stop mode trips the monitor
        @(posedge sys_clk);
        stop_mode <= 1'b1;
        tick_on <= 1'b0;
        wait_oe(1'b1, 100);
        chk(n >= 40 && n <= 70, 1'b1, "monitor trip");
        repeat (200) @(posedge sys_clk);
        rd_reg(ADDR_STAT, q);
        chk({fault_pin_oe, q[ST_CMERR]}, 2'b11, "monitor hold");
        chk({q[ST_CMFAIL], fault_pin_o, level}, 3'b100, "monitor live");
        @(posedge sys_clk);
        tick_on <= 1'b1;
        stop_mode <= 1'b0;
        pulse_end(0);
        service(8'h19, 1'b1);
        boot_pulse(1'b0);
        service(8'h19, 1'b0);
        boot_pulse(1'b1);
        @(posedge sys_clk);
        option_byte <= 8'h04;
        repeat (2) @(posedge sys_clk);
        #1 chk(fault_pullup_en, 1'b0, "pull-up off");
        service(8'h00, 1'b0);
        give_verdict;
    end
endmodule : watchdog_clock_monitor_tb
